// ---- core/pbc_pkg.sv ----
// package: register map, field positions, reset values and timing for pbc
package pbc_pkg;
    localparam logic [7:0] CTL2_IDX   = 8'h41;
    localparam logic [7:0] RSVD_IDX   = 8'h42;
    localparam logic [7:0] ARB1_IDX   = 8'h43;
    localparam logic [7:0] CTL2_RST   = 8'h96;
    localparam logic [7:0] RSVD_RST   = 8'h00;
    localparam logic [7:0] ARB1_RST   = 8'h80;
    // bridge_control_two fields
    localparam int CTL2_RSVD_BIT  = 7;
    localparam int RAW_CLK_BIT    = 6;
    localparam int SERR_FORCE_BIT = 5;
    localparam int POST_BIT       = 4;
    localparam int DISC_SIZE_LO   = 2;
    localparam int LINE_SEL_BIT   = 1;
    localparam int WR_WAIT_BIT    = 0;
    // arbiter_control_one fields
    localparam int GNT_EMPTY_BIT  = 7;
    localparam int ARB1_RSVD_BIT  = 6;
    localparam int MASK_EN_LO     = 3;
    localparam int MASK_LEN_LO    = 1;
    localparam int HOLD_RETRY_BIT = 0;
    // timing, in PCI clocks
    localparam logic [6:0] MASK_16 = 7'h10;
    localparam logic [6:0] MASK_32 = 7'h20;
    localparam logic [6:0] MASK_64 = 7'h40;
    localparam logic [1:0] HOLD_EXTRA  = 2'h2;
    localparam logic [1:0] WR_WAIT_CYC = 2'h1;
    localparam int NUM_REQ = 3;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } pbc_cfg_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic is_mem;
        logic locked;
    } pbc_xcyc_s;
endpackage

// ---- core/pbc_bridge_cfg.sv ----
// pbc_bridge_cfg: PCI bridge control bits and arbiter grant qualification
`timescale 1ns/10ps
`default_nettype none

module pbc_bridge_cfg (
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire pbc_pkg::pbc_cfg_req_s i_cfg,
    output logic [7:0]                 o_cfg_rdata,
    output logic                       o_cfg_rvalid,
    input  wire logic                  i_perr_drive,
    input  wire logic                  i_perr_seen,
    output logic                       o_serr_n_o,
    output logic                       o_serr_n_oe,
    input  wire pbc_pkg::pbc_xcyc_s    i_xcyc,
    output logic                       o_post_write,
    input  wire logic                  i_slv_xfer,
    input  wire logic [11:0]           i_slv_addr,
    output logic                       o_slv_disconnect,
    input  wire logic                  i_xwr_start,
    output logic                       o_xwr_wait,
    input  wire logic                  i_raw_clk,
    output logic                       o_raw_clk_obs,
    input  wire logic [2:0]            i_req,
    input  wire logic [2:0]            i_arb_gnt,
    input  wire logic                  i_xbuf_empty,
    input  wire logic                  i_retry_done,
    input  wire logic [2:0]            i_retry_master,
    input  wire logic                  i_xhold_req,
    output logic [2:0]                 o_req_eff,
    output logic [2:0]                 o_gnt,
    output logic                       o_xhold
);

    logic [7:0] ctl2_r;
    logic [7:0] arb1_r;
    logic [2:0] masked;
    logic [1:0] hold_cnt_r;
    logic [1:0] wait_cnt_r;
    logic [2:0] raw_sync_r;
    logic [9:0] bound_mask;
    logic [6:0] mask_len;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl2_r <= pbc_pkg::CTL2_RST;
            arb1_r <= pbc_pkg::ARB1_RST;
        end else if (i_cfg.wr) begin
            if (i_cfg.addr == pbc_pkg::CTL2_IDX) begin
                ctl2_r <= i_cfg.wdata;
                ctl2_r[pbc_pkg::CTL2_RSVD_BIT] <= 1'b0;
            end
            if (i_cfg.addr == pbc_pkg::ARB1_IDX) begin
                arb1_r <= i_cfg.wdata;
                arb1_r[pbc_pkg::ARB1_RSVD_BIT] <= 1'b1;
            end
        end
    end

    // reads answer one clock later; unmapped indices read zero
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cfg_rdata  <= 8'h00;
            o_cfg_rvalid <= 1'b0;
        end else begin
            o_cfg_rvalid <= i_cfg.rd;
            unique case (i_cfg.addr)
                pbc_pkg::CTL2_IDX: o_cfg_rdata <= ctl2_r;
                pbc_pkg::RSVD_IDX: o_cfg_rdata <= pbc_pkg::RSVD_RST;
                pbc_pkg::ARB1_IDX: o_cfg_rdata <= arb1_r;
                default:           o_cfg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master side: error forcing and write posting
    assign o_serr_n_o = 1'b0;

    // open drain: enable low while pulling SERR low
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_serr_n_oe <= 1'b1;
        end else begin
            o_serr_n_oe <= ~(ctl2_r[pbc_pkg::SERR_FORCE_BIT] &
                             (i_perr_drive | i_perr_seen));
        end
    end

    // io and locked cycles stay unposted to keep ordering and atomicity
    assign o_post_write = ctl2_r[pbc_pkg::POST_BIT] & i_xcyc.valid &
                          i_xcyc.write & i_xcyc.is_mem &
                          ~i_xcyc.locked;

    ////////////////////////////////////////////////////////////////////////
    // slave side: burst disconnect boundary
    always_comb begin
        if (ctl2_r[pbc_pkg::LINE_SEL_BIT]) begin
            bound_mask = 10'h00f;
        end else begin
            unique case (ctl2_r[pbc_pkg::DISC_SIZE_LO +: 2])
                2'h0: bound_mask = 10'h07f;
                2'h1: bound_mask = 10'h0ff;
                2'h2: bound_mask = 10'h1ff;
                2'h3: bound_mask = 10'h3ff;
            endcase
        end
    end

    // disconnect on the last dword before the boundary
    assign o_slv_disconnect = i_slv_xfer &
        (&(i_slv_addr[9:2] | ~bound_mask[9:2]));

    // wait states on slave-initiated internal bus writes
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_cnt_r <= 2'h0;
        end else if (i_xwr_start & ctl2_r[pbc_pkg::WR_WAIT_BIT]) begin
            wait_cnt_r <= pbc_pkg::WR_WAIT_CYC;
        end else if (wait_cnt_r != 2'h0) begin
            wait_cnt_r <= wait_cnt_r - 2'h1;
        end
    end
    assign o_xwr_wait = (wait_cnt_r != 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // debug raw clock view; only stage 2 and 3 are looked at
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            raw_sync_r <= 3'h0;
        end else begin
            raw_sync_r <= {raw_sync_r[1:0], i_raw_clk};
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_raw_clk_obs <= 1'b0;
        end else if (!ctl2_r[pbc_pkg::RAW_CLK_BIT]) begin
            o_raw_clk_obs <= 1'b0;
        end else if (raw_sync_r[2] == raw_sync_r[1]) begin
            o_raw_clk_obs <= raw_sync_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arbiter: retry masking per request line
    always_comb begin
        unique case (arb1_r[pbc_pkg::MASK_LEN_LO +: 2])
            2'h0: mask_len = 7'h00;
            2'h1: mask_len = pbc_pkg::MASK_16;
            2'h2: mask_len = pbc_pkg::MASK_32;
            2'h3: mask_len = pbc_pkg::MASK_64;
        endcase
    end

    for (genvar g = 0; g < pbc_pkg::NUM_REQ; g++) begin : g_mask
        logic [6:0] cnt_r;
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                cnt_r <= 7'h00;
            end else if (i_retry_done & i_retry_master[g] &
                         arb1_r[pbc_pkg::MASK_EN_LO + g]) begin
                cnt_r <= mask_len;
            end else if (cnt_r != 7'h00) begin
                cnt_r <= cnt_r - 7'h01;
            end
        end
        assign masked[g] = (cnt_r != 7'h00);
    end

    assign o_req_eff = i_req & ~masked;
    // grants also dropped for masked lines so the core cannot race it
    assign o_gnt = i_arb_gnt & ~masked &
        {3{~arb1_r[pbc_pkg::GNT_EMPTY_BIT] | i_xbuf_empty}};

    // internal bus hold stretch after a retry
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold_cnt_r <= 2'h0;
        end else if (i_retry_done & arb1_r[pbc_pkg::HOLD_RETRY_BIT]) begin
            hold_cnt_r <= pbc_pkg::HOLD_EXTRA;
        end else if (hold_cnt_r != 2'h0) begin
            hold_cnt_r <= hold_cnt_r - 2'h1;
        end
    end
    assign o_xhold = i_xhold_req | (hold_cnt_r != 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_serr_force;
        @(posedge i_clk) disable iff (i_sys_rst)
        (ctl2_r[pbc_pkg::SERR_FORCE_BIT] && i_perr_seen) |=> !o_serr_n_oe;
    endproperty
    a_serr_force: assert property (p_serr_force)
        else $error("serr not forced on perr");

    property p_no_post_io;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_xcyc.is_mem || i_xcyc.locked) |-> !o_post_write;
    endproperty
    a_no_post_io: assert property (p_no_post_io)
        else $error("io or locked write posted");

    property p_line_disc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (ctl2_r[pbc_pkg::LINE_SEL_BIT] && i_slv_xfer)
            |-> (o_slv_disconnect == (i_slv_addr[3:2] == 2'h3));
    endproperty
    a_line_disc: assert property (p_line_disc)
        else $error("line disconnect wrong");

    property p_128_disc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (ctl2_r[3:1] == 3'h0 && i_slv_xfer)
            |-> (o_slv_disconnect == (i_slv_addr[6:2] == 5'h1f));
    endproperty
    a_128_disc: assert property (p_128_disc)
        else $error("128 byte disconnect wrong");

    property p_grant_qual;
        @(posedge i_clk) disable iff (i_sys_rst)
        (arb1_r[pbc_pkg::GNT_EMPTY_BIT] && !i_xbuf_empty) |-> (o_gnt == 3'h0);
    endproperty
    a_grant_qual: assert property (p_grant_qual)
        else $error("grant with buffers busy");

    property p_mask16;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_retry_done && i_retry_master[0] && arb1_r[3:1] == 3'h5)
            |=> masked[0] [*8] ##9 !masked[0];
    endproperty
    a_mask16: assert property (p_mask16)
        else $error("sixteen clock mask wrong");

    property p_no_mask_dis;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_retry_done && !arb1_r[pbc_pkg::MASK_EN_LO] && !masked[0])
            |=> !masked[0];
    endproperty
    a_no_mask_dis: assert property (p_no_mask_dis)
        else $error("disabled line masked");

    property p_hold_two;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_retry_done && arb1_r[pbc_pkg::HOLD_RETRY_BIT]) |=> o_xhold [*2];
    endproperty
    a_hold_two: assert property (p_hold_two)
        else $error("hold not stretched");

    property p_ctl2_rsvd;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_cfg.wr && i_cfg.addr == pbc_pkg::CTL2_IDX)
            |=> !ctl2_r[pbc_pkg::CTL2_RSVD_BIT];
    endproperty
    a_ctl2_rsvd: assert property (p_ctl2_rsvd)
        else $error("reserved bit wrong");

    property p_raw_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        !ctl2_r[pbc_pkg::RAW_CLK_BIT] |=> !o_raw_clk_obs;
    endproperty
    a_raw_off: assert property (p_raw_off)
        else $error("raw clock seen while off");

    property p_wait;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_xwr_start && ctl2_r[pbc_pkg::WR_WAIT_BIT]) |=> o_xwr_wait;
    endproperty
    a_wait: assert property (p_wait)
        else $error("no write wait state");

    property p_unmask;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!masked[1] && !(i_retry_done && i_retry_master[1]))
            |=> !masked[1];
    endproperty
    a_unmask: assert property (p_unmask)
        else $error("mask without retry");

endmodule // pbc_bridge_cfg
`default_nettype wire

// ---- test/pbc_pci_peer.sv ----
// pbc_pci_peer: external PCI masters that keep requesting and get retried
`timescale 1ns/10ps
`default_nettype none

module pbc_pci_peer (
    input  wire logic  i_clk,
    output logic [2:0] o_req,
    output logic       o_retry_done,
    output logic [2:0] o_retry_master
);
    initial begin
        o_req          = 3'h7;
        o_retry_done   = 1'b0;
        o_retry_master = 3'h0;
    end

    // a retried master keeps its request up, so masking shows at once
    task automatic retry(input logic [2:0] g);
        @(posedge i_clk);
        #1;
        o_retry_done   = 1'b1;
        o_retry_master = g;
        @(posedge i_clk);
        #1;
        o_retry_done   = 1'b0;
        // released: a changed pattern, not the last value
        o_retry_master = ~g;
    endtask
endmodule // pbc_pci_peer
`default_nettype wire

// ---- test/pbc_bridge_cfg_test.sv ----
// pbc_bridge_cfg_test: one task per scenario for the bridge control block
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, want) begin \
    check_count++; \
    if ((got) !== (want)) begin \
        err_count++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want); \
    end \
end

module pbc_bridge_cfg_test;
    logic       i_clk, i_sys_rst, i_perr_drive, i_perr_seen, i_slv_xfer;
    logic       i_xwr_start, i_raw_clk, i_xbuf_empty, i_retry_done;
    logic       i_xhold_req, o_cfg_rvalid, o_serr_n_o, o_serr_n_oe;
    logic       o_post_write, o_slv_disconnect, o_xwr_wait;
    logic       o_raw_clk_obs, o_xhold;
    logic [2:0] i_req, i_arb_gnt, i_retry_master, o_req_eff, o_gnt;
    logic [7:0] o_cfg_rdata;
    logic [11:0] i_slv_addr;
    pbc_pkg::pbc_cfg_req_s i_cfg;
    pbc_pkg::pbc_xcyc_s    i_xcyc;
    int         err_count, check_count;

    pbc_bridge_cfg dut (
        .i_clk, .i_sys_rst, .i_cfg, .o_cfg_rdata, .o_cfg_rvalid,
        .i_perr_drive, .i_perr_seen, .o_serr_n_o, .o_serr_n_oe, .i_xcyc,
        .o_post_write, .i_slv_xfer, .i_slv_addr, .o_slv_disconnect,
        .i_xwr_start, .o_xwr_wait, .i_raw_clk, .o_raw_clk_obs, .i_req,
        .i_arb_gnt, .i_xbuf_empty, .i_retry_done, .i_retry_master,
        .i_xhold_req, .o_req_eff, .o_gnt, .o_xhold
    );
    pbc_pci_peer peer (
        .i_clk, .o_req(i_req), .o_retry_done(i_retry_done),
        .o_retry_master(i_retry_master)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // debug clock runs free, out of phase with i_clk
    initial begin
        i_raw_clk = 1'b0;
        #13;
        forever #40 i_raw_clk = ~i_raw_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick;
        i_cfg.addr  = a;
        i_cfg.wdata = d;
        i_cfg.wr    = 1'b1;
        tick;
        i_cfg.wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        tick;
        i_cfg.addr = a;
        i_cfg.rd   = 1'b1;
        tick;
        i_cfg.rd = 1'b0;
        `CHK({o_cfg_rvalid, o_cfg_rdata}, {1'b1, e})
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd_chk(8'h41, 8'h96);
        rd_chk(8'h43, 8'h80);
        rd_chk(8'h42, 8'h00);
        wr(8'h41, 8'hff);
        rd_chk(8'h41, 8'h7f);
        wr(8'h43, 8'h00);
        rd_chk(8'h43, 8'h40);
        wr(8'h42, 8'hff);
        rd_chk(8'h42, 8'h00);
        rd_chk(8'h50, 8'h00);
    endtask
    task automatic t_serr;
        wr(8'h41, 8'h00);
        i_perr_seen = 1'b1;
        repeat (2) tick;
        `CHK(o_serr_n_oe, 1'b1)
        wr(8'h41, 8'h20);
        tick;
        `CHK({o_serr_n_oe, o_serr_n_o}, 2'b00)
        i_perr_seen  = 1'b0;
        i_perr_drive = 1'b1;
        repeat (2) tick;
        `CHK(o_serr_n_oe, 1'b0)
        i_perr_drive = 1'b0;
        repeat (2) tick;
        `CHK(o_serr_n_oe, 1'b1)
    endtask
    task automatic t_post;
        logic [3:0] cyc [5] = '{4'he, 4'hc, 4'hf, 4'ha, 4'he};
        logic       want [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        wr(8'h41, 8'h10);
        for (int k = 0; k < 5; k++) begin
            if (k == 4) wr(8'h41, 8'h00);
            i_xcyc = cyc[k];
            tick;
            `CHK(o_post_write, want[k])
        end
    endtask
    // each boundary, then the 16-byte line override
    task automatic t_disc;
        int b;
        i_slv_xfer = 1'b1;
        for (int s = 0; s < 5; s++) begin
            wr(8'h41, s == 4 ? 8'h02 : 8'(s << 2));
            b = s == 4 ? 16 : 128 << s;
            i_slv_addr = 12'(b - 4);
            tick;
            `CHK(o_slv_disconnect, 1'b1)
            i_slv_addr = 12'(b - 8);
            tick;
            `CHK(o_slv_disconnect, 1'b0)
        end
        i_slv_xfer = 1'b0;
    endtask
    task automatic t_wait;
        for (int x = 0; x < 2; x++) begin
            wr(8'h41, 8'(x));
            i_xwr_start = 1'b1;
            tick;
            i_xwr_start = 1'b0;
            `CHK(o_xwr_wait, x[0])
            tick;
            `CHK(o_xwr_wait, 1'b0)
        end
    endtask
    task automatic t_raw;
        int   n;
        logic p;
        for (int x = 0; x < 2; x++) begin
            wr(8'h41, {1'b0, x[0], 6'h0});
            repeat (8) tick;
            n = 0;
            repeat (64) begin
                p = o_raw_clk_obs;
                tick;
                if (o_raw_clk_obs !== p) n++;
            end
            `CHK(n != 0, x == 1)
        end
    endtask
    task automatic t_gnt;
        wr(8'h43, 8'hc0);
        i_xbuf_empty = 1'b0;
        tick;
        `CHK(o_gnt, 3'h0)
        i_xbuf_empty = 1'b1;
        #1;
        `CHK(o_gnt, 3'h7)
        wr(8'h43, 8'h40);
        i_xbuf_empty = 1'b0;
        #1;
        `CHK(o_gnt, 3'h7)
        i_xbuf_empty = 1'b1;
    endtask
    // retry master g; count the clocks its request stays hidden
    task automatic mask_run(input int g, input int m, input logic en,
                            input int e);
        int n;
        wr(8'h43, {2'b01, en ? 3'(1 << g) : ~3'(1 << g), 2'(m), 1'b0});
        peer.retry(3'(1 << g));
        `CHK(o_gnt[g], e == 0)
        n = 0;
        while (o_req_eff[g] === 1'b0 && n < 200) begin
            n++;
            tick;
        end
        `CHK(n, e)
    endtask
    task automatic t_hold;
        int n;
        for (int h = 0; h < 2; h++) begin
            wr(8'h43, {7'h20, h[0]});
            peer.retry(3'h1);
            n = 0;
            while (o_xhold === 1'b1 && n < 20) begin
                n++;
                tick;
            end
            `CHK(n, 2 * h)
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        err_count    = 0;
        check_count  = 0;
        i_sys_rst    = 1'b1;
        i_cfg        = '0;
        i_xcyc       = '0;
        i_perr_drive = 1'b0;
        i_perr_seen  = 1'b0;
        i_slv_xfer   = 1'b0;
        i_slv_addr   = 12'h000;
        i_xwr_start  = 1'b0;
        i_arb_gnt    = 3'h7;
        i_xbuf_empty = 1'b1;
        i_xhold_req  = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        t_regs;
        t_serr;
        t_post;
        t_disc;
        t_wait;
        t_raw;
        t_gnt;
        for (int m = 0; m < 4; m++)
            for (int g = 0; g < 3; g++)
                mask_run(g, m, 1'b1, m == 0 ? 0 : 8 << m);
        mask_run(1, 3, 1'b0, 0);
        t_hold;
        wrap_up;
    end
    // whole run is about 620 clocks; this is some 80 times that
    initial begin
        #500000;
        err_count++;
        wrap_up;
    end
endmodule // pbc_bridge_cfg_test
`default_nettype wire
